// File: eewp_pkg.sv
// Shared constants and types for the serial EEPROM write-protect slave pair
package eewp_pkg;

  // ---------------------------------------------------------------
  // Addressing
  // ---------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [1:0] DEV_SELECT = 2'h0;
  localparam logic [15:0] CTRL_ADDR = 16'hffff;
  localparam int ARR_W = 14;
  localparam int OFF_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int ARRAY_BYTES = 16384;

  // ---------------------------------------------------------------
  // Control register layout and commands
  // ---------------------------------------------------------------
  localparam int CR_HWPE = 7;
  localparam int CR_WD1 = 6;
  localparam int CR_WD0 = 5;
  localparam int CR_BP1 = 4;
  localparam int CR_BP0 = 3;
  localparam int CR_REGISTER_WRITE_ENABLE_LATCH = 2;
  localparam int CR_WEL = 1;
  localparam int CR_BP2 = 0;
  localparam logic [7:0] CTRL_NV_RESET = 8'h60;
  localparam logic [7:0] CMD_SET_WEL = 8'h02;
  localparam logic [7:0] CMD_SET_REGISTER_WRITE_ENABLE_LATCH = 8'h06;
  localparam logic [7:0] CMD_CLR_WEL = 8'h00;

  // ---------------------------------------------------------------
  // Block protect boundaries
  // ---------------------------------------------------------------
  localparam logic [13:0] PROT_Q4_BASE = 14'h3000;
  localparam logic [13:0] PROT_HALF_BASE = 14'h2000;
  localparam logic [13:0] PROT_P1_END = 14'h0040;
  localparam logic [13:0] PROT_P2_END = 14'h0080;
  localparam logic [13:0] PROT_P4_END = 14'h0100;
  localparam logic [13:0] PROT_P8_END = 14'h0200;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_MS = 10;
  localparam int WRITE_CYCLES_DEF = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int BUSY_W = 20;
  localparam int QUARTER_CYCLES = 3;

  // ---------------------------------------------------------------
  // Host command word and buffering
  // ---------------------------------------------------------------
  localparam int CMD_W = 11;
  localparam int CMD_START = 10;
  localparam int CMD_STOP = 9;
  localparam int CMD_READ = 8;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    DS_IDLE, DS_RX, DS_ACKW, DS_ACK, DS_TX, DS_TXACK, DS_BUSY
  } eewp_dev_state_type;

  typedef enum logic [1:0] {
    HS_IDLE, HS_START, HS_BITS, HS_STOP
  } eewp_host_state_type;

endpackage

// File: eewp_if.sv
// Two-wire bus between the bus master and the EEPROM slave
`timescale 1ns/1ps
`default_nettype none
interface eewp_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic sda;

  // Open drain with pull-up: any enabled low wins
  assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));

  modport host (output scl, output sda_m_out, output sda_m_oe, input sda);
  modport device (input scl, output sda_s_out, output sda_s_oe, input sda);
endinterface
`default_nettype wire

// File: eewp_device.sv
// EEPROM slave end: bus framing, page writes, control register protection
//
// How it works
// RQ1: Hardware protect needs pin high and enable bit
// RQ2: Hardware protect blocks protect and enable bits
// RQ3: Writes to protected blocks ignored and not acknowledged
// RQ4: Step one: 02H sets write enable latch
// RQ5: Step two: 06H sets both enable latches
// RQ6: Step three: nonvolatile store, then register latch clears
// RQ7: Bit two set keeps register latch set
// RQ8: Second control data byte aborts with no-acknowledge
// RQ9: Reads between steps leave sequence untouched
// RQ10: Register latch clears only on listed events
// RQ11: Data changes only while clock low
// RQ12: Ignore bus until start condition seen
// RQ13: Stop returns device to standby
// RQ14: Acknowledge each byte except wrong slave address and refused data bytes
// RQ15: Transmit byte, sample acknowledge, continue or stop
// RQ16: Byte write acknowledged; stop starts write cycle
// RQ17: Busy cycle ignores bus, data line released
// RQ18: Page write wraps in-page address only
// RQ19: Extra page bytes overwrite earlier buffered bytes
// RQ20: Early stop resets without writing array
// RQ21: Master starts transfers and drives the clock
// RQ22: Write enable latch low refuses all writes except step one (02H to the control register)
// RQ23: Control register sits at word address FFFFh
// RQ24: Write cycle timed by parameter counter
`timescale 1ns/1ps
`default_nettype none
module eewp_device #(
  parameter int WRITE_CYCLES = eewp_pkg::WRITE_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Write-protect pin
  input wire logic wp_pin,
  // Two-wire bus
  eewp_if.device bus,
  // Status
  output logic busy,
  output logic [7:0] ctrl_value
);
  import eewp_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] mem [ARRAY_BYTES];
  logic [7:0] pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvalid;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  eewp_dev_state_type state;
  logic [1:0] scl_sync, sda_sync, wp_sync;
  logic scl_q, sda_q;
  logic [3:0] bit_cnt;
  logic [7:0] shift, tx_shift, ctrl_data;
  logic [1:0] byte_idx;
  logic rd_mode, ack_go, data_ok, sda_drive, ctrl_got;
  logic [15:0] addr;
  logic [BUSY_W-1:0] busy_cnt;
  logic write_enable_latch, register_write_enable_latch, hwpe;
  logic [1:0] wd;
  logic [2:0] bp;

  function automatic logic blocked(input logic [13:0] a,
                                   input logic [2:0] b);
    case (b)
      3'h1: blocked = a >= PROT_Q4_BASE;
      3'h2: blocked = a >= PROT_HALF_BASE;
      3'h3: blocked = 1'b1;
      3'h4: blocked = a < PROT_P1_END;
      3'h5: blocked = a < PROT_P2_END;
      3'h6: blocked = a < PROT_P4_END;
      3'h7: blocked = a < PROT_P8_END;
      default: blocked = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Bus events
  // ---------------------------------------------------------------
  wire scl_now = scl_sync[1];
  wire sda_now = sda_sync[1];
  // RQ11 RQ12 RQ13
  wire start_ev = scl_now & scl_q & sda_q & ~sda_now;
  wire stop_ev = scl_now & scl_q & ~sda_q & sda_now;
  wire rise = scl_now & ~scl_q;
  wire fall = ~scl_now & scl_q;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire hw_protect = wp_sync[1] & hwpe; // RQ1
  wire is_ctrl = addr == CTRL_ADDR; // RQ23
  wire [7:0] rx_byte = {shift[6:0], sda_now};
  wire addr_match = (rx_byte[7:4] == DEV_TYPE) & ~rx_byte[3]
                    & (rx_byte[2:1] == DEV_SELECT);
  wire arr_blocked = blocked(addr[13:0], bp); // RQ3
  wire rx_nv = register_write_enable_latch & rx_byte[CR_WEL] & (rx_byte != CMD_SET_REGISTER_WRITE_ENABLE_LATCH);
  // Step one must get through while the enable latch is still low
  wire wel_gate = write_enable_latch | (rx_byte == CMD_SET_WEL); // RQ4 RQ22
  wire ctrl_ok = wel_gate & ~ctrl_got
                 & ~(rx_nv & hw_protect); // RQ2 RQ8 RQ22
  wire data_ack = is_ctrl ? ctrl_ok : (write_enable_latch & ~arr_blocked); // RQ3 RQ22
  wire byte_ack = (byte_idx == 2'h0) ? addr_match :
                  (byte_idx == 2'h3) ? data_ack : 1'b1; // RQ14
  wire byte_done = (state == DS_RX) & rise & (bit_cnt == 4'h7);
  wire take_data = byte_done & (byte_idx == 2'h3) & ~rd_mode;
  wire cd_nv = register_write_enable_latch & ctrl_data[CR_WEL] & (ctrl_data != CMD_SET_REGISTER_WRITE_ENABLE_LATCH);
  // A stop counts only right after a full data byte and its acknowledge
  wire commit = stop_ev & data_ok & (state == DS_RX)
                & (bit_cnt <= 4'h1) & (byte_idx == 2'h3); // RQ20
  wire start_nv = commit & (~is_ctrl | cd_nv); // RQ16 RQ6
  wire nv_done = (state == DS_BUSY) & (busy_cnt == BUSY_W'(1));
  wire [7:0] ctrl_read = {hwpe, wd, bp[1:0], register_write_enable_latch, write_enable_latch, bp[2]};
  wire [7:0] tx_load = is_ctrl ? ctrl_read : mem[addr[13:0]];

  assign busy = state == DS_BUSY;
  assign ctrl_value = ctrl_read;
  assign bus.sda_s_out = 1'b0;
  assign bus.sda_s_oe = sda_drive;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      wp_sync <= 2'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en) begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      wp_sync <= {wp_sync[0], wp_pin};
      scl_q <= scl_now;
      sda_q <= sda_now;
    end
  end

  // ---------------------------------------------------------------
  // Bus state machine
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= DS_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx_shift <= 8'h00;
      byte_idx <= 2'h0;
      rd_mode <= 1'b0;
      ack_go <= 1'b0;
      data_ok <= 1'b0;
      sda_drive <= 1'b0;
      addr <= 16'h0000;
      busy_cnt <= '0;
    end else if (clk_en) begin
      if (state == DS_BUSY) begin
        // Inputs are deaf until the cell write finishes
        sda_drive <= 1'b0; // RQ17
        busy_cnt <= busy_cnt - 1'b1; // RQ24
        if (nv_done) begin
          state <= DS_IDLE;
        end
      end else if (start_nv) begin
        state <= DS_BUSY; // RQ16
        busy_cnt <= BUSY_W'(WRITE_CYCLES); // RQ24
        sda_drive <= 1'b0;
      end else if (start_ev) begin
        state <= DS_RX; // RQ12
        bit_cnt <= 4'h0;
        byte_idx <= 2'h0;
        data_ok <= 1'b0;
        sda_drive <= 1'b0;
      end else if (stop_ev) begin
        state <= DS_IDLE; // RQ13 RQ20
        sda_drive <= 1'b0;
      end else begin
        case (state)
          DS_RX: begin
            if (rise) begin
              shift <= rx_byte;
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt == 4'h7) begin
                ack_go <= byte_ack;
                state <= DS_ACKW;
                if (byte_idx == 2'h0) begin
                  rd_mode <= rx_byte[0];
                end
                if (byte_idx == 2'h1) begin
                  addr[15:8] <= rx_byte;
                end
                if (byte_idx == 2'h2) begin
                  addr[7:0] <= rx_byte;
                end
              end
            end
          end
          DS_ACKW: begin
            if (fall) begin
              sda_drive <= ack_go; // RQ14 RQ3
              state <= ack_go ? DS_ACK : DS_IDLE;
            end
          end
          DS_ACK: begin
            if (fall) begin
              bit_cnt <= 4'h0;
              if (byte_idx != 2'h3) begin
                byte_idx <= byte_idx + 1'b1;
              end
              data_ok <= data_ok | ((byte_idx == 2'h3) & ~rd_mode);
              if ((byte_idx == 2'h3) & ~rd_mode & ~is_ctrl) begin
                addr[5:0] <= addr[5:0] + 1'b1; // RQ18
              end
              if (rd_mode) begin
                state <= DS_TX;
                tx_shift <= tx_load;
                sda_drive <= ~tx_load[7];
              end else begin
                state <= DS_RX;
                sda_drive <= 1'b0;
              end
            end
          end
          DS_TX: begin
            if (rise) begin
              bit_cnt <= bit_cnt + 1'b1;
            end else if (fall) begin
              if (bit_cnt == 4'h8) begin
                sda_drive <= 1'b0; // RQ15
                state <= DS_TXACK;
              end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                sda_drive <= ~tx_shift[6];
              end
            end
          end
          DS_TXACK: begin
            if (rise) begin
              // Control register reads end after one byte
              if (~sda_now & ~is_ctrl) begin
                addr <= {2'h0, addr[13:0] + 1'b1}; // RQ15
                state <= DS_ACK;
              end else begin
                state <= DS_IDLE; // RQ15
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Enable latches and control bits
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_enable_latch <= 1'b0;
      register_write_enable_latch <= 1'b0;
      hwpe <= CTRL_NV_RESET[CR_HWPE];
      wd <= {CTRL_NV_RESET[CR_WD1], CTRL_NV_RESET[CR_WD0]};
      bp <= {CTRL_NV_RESET[CR_BP2], CTRL_NV_RESET[CR_BP1],
             CTRL_NV_RESET[CR_BP0]};
      ctrl_data <= 8'h00;
      ctrl_got <= 1'b0;
    end else if (clk_en) begin
      if (byte_done & (byte_idx == 2'h2)) begin
        ctrl_got <= 1'b0;
      end
      if (take_data & is_ctrl) begin
        ctrl_got <= 1'b1; // RQ8
        if (ctrl_ok) begin
          ctrl_data <= rx_byte;
        end
      end
      if (take_data & ~is_ctrl & arr_blocked) begin
        register_write_enable_latch <= 1'b0; // RQ10
      end
      // Volatile steps take effect at the stop with no busy time
      if (commit & is_ctrl & ~cd_nv) begin
        if (ctrl_data == CMD_SET_WEL) begin
          write_enable_latch <= 1'b1; // RQ4
        end else if (ctrl_data == CMD_SET_REGISTER_WRITE_ENABLE_LATCH) begin
          write_enable_latch <= 1'b1; // RQ5
          register_write_enable_latch <= 1'b1; // RQ5
        end else if (ctrl_data == CMD_CLR_WEL) begin
          write_enable_latch <= 1'b0;
        end
      end
      if (nv_done & is_ctrl) begin
        hwpe <= ctrl_data[CR_HWPE]; // RQ6
        wd <= {ctrl_data[CR_WD1], ctrl_data[CR_WD0]};
        bp <= {ctrl_data[CR_BP2], ctrl_data[CR_BP1], ctrl_data[CR_BP0]};
        if (~ctrl_data[CR_REGISTER_WRITE_ENABLE_LATCH]) begin
          register_write_enable_latch <= 1'b0; // RQ6 RQ7 RQ10
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Page buffer and array
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pvalid <= '0;
    end else if (clk_en) begin
      if (byte_done & (byte_idx == 2'h2)) begin
        pvalid <= '0;
      end else if (take_data & ~is_ctrl & data_ack) begin
        pvalid[addr[5:0]] <= 1'b1; // RQ19
      end
    end
  end

  // Array has no reset; every buffered byte of the page lands in one clock
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (take_data & ~is_ctrl & data_ack) begin
        pbuf[addr[5:0]] <= rx_byte; // RQ19
      end
      if (nv_done & ~is_ctrl) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (pvalid[i]) begin
            mem[{addr[13:6], OFF_W'(i)}] <= pbuf[i]; // RQ16 RQ18
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: eewp_host.sv
// Bus master end: command FIFO feeding a bit-level two-wire sequencer
`timescale 1ns/1ps
`default_nettype none
module eewp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0] count;
  wire push = in_valid & in_ready & clk_en;
  wire pop = out_valid & out_ready & clk_en;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module eewp_host (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Command stream: start, stop, read flags and write byte
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [eewp_pkg::CMD_W-1:0] cmd_data,
  // Results
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic ack_seen,
  output logic idle,
  // Two-wire bus
  eewp_if.host bus
);
  import eewp_pkg::*;

  eewp_host_state_type state;
  logic [CMD_W-1:0] cur;
  logic [1:0] q;
  logic [1:0] qcnt;
  logic [3:0] bit_idx;
  logic [1:0] sda_sync;
  logic [7:0] rx_shift;
  logic scl_o, sda_low;
  logic f_valid;
  logic [CMD_W-1:0] f_data;

  // ---------------------------------------------------------------
  // Command buffer
  // ---------------------------------------------------------------
  wire f_pop = (state == HS_IDLE);
  eewp_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // ---------------------------------------------------------------
  // Quarter-bit waveform
  // ---------------------------------------------------------------
  wire tick = qcnt == 2'(QUARTER_CYCLES - 1);
  wire rd = cur[CMD_READ];
  wire sda_in = sda_sync[1];
  // Master owns the clock and starts every transfer
  wire want_scl = (q == 2'h1) | (q == 2'h2)
                  | ((state == HS_STOP) & (q != 2'h0)); // RQ21
  wire bit_low = (bit_idx == 4'h8) ? (rd & ~cur[CMD_STOP])
                 : (~rd & ~cur[3'(4'h7 - bit_idx)]);
  wire want_low = (state == HS_START) ? (q[1]) :
                  (state == HS_STOP) ? (~q[1]) : bit_low; // RQ11

  assign bus.scl = scl_o;
  assign bus.sda_m_out = 1'b0;
  assign bus.sda_m_oe = sda_low;
  assign idle = (state == HS_IDLE) & ~f_valid;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_sync <= 2'h3;
    end else if (clk_en) begin
      sda_sync <= {sda_sync[0], bus.sda};
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= HS_IDLE;
      cur <= '0;
      q <= 2'h0;
      qcnt <= 2'h0;
      bit_idx <= 4'h0;
      rx_shift <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      ack_seen <= 1'b0;
      scl_o <= 1'b1;
      sda_low <= 1'b0;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      if (state == HS_IDLE) begin
        if (f_valid) begin
          cur <= f_data;
          state <= f_data[CMD_START] ? HS_START : HS_BITS;
          q <= 2'h0;
          qcnt <= 2'h0;
          bit_idx <= 4'h0;
        end
      end else begin
        scl_o <= want_scl;
        sda_low <= want_low;
        qcnt <= tick ? 2'h0 : qcnt + 1'b1;
        if (tick) begin
          q <= q + 1'b1;
          if ((state == HS_BITS) & (q == 2'h2)) begin
            if (bit_idx != 4'h8) begin
              rx_shift <= {rx_shift[6:0], sda_in};
            end else if (~rd) begin
              ack_seen <= ~sda_in;
            end
          end
          if (q == 2'h3) begin
            if (state == HS_START) begin
              state <= HS_BITS;
            end else if (state == HS_STOP) begin
              state <= HS_IDLE;
            end else if (bit_idx == 4'h8) begin
              rx_valid <= rd;
              rx_data <= rx_shift;
              state <= cur[CMD_STOP] ? HS_STOP : HS_IDLE;
            end else begin
              bit_idx <= bit_idx + 1'b1;
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: eewp_sva.sv
// Bus-level assertions for the EEPROM write-protect slave pair
`timescale 1ns/1ps
`default_nettype none
module eewp_sva
  import eewp_pkg::*;
#(
  parameter int WRITE_CYCLES = 200
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bus lines and device status
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  input wire logic wp_pin,
  input wire logic busy,
  input wire logic [7:0] ctrl_value
);
  logic [19:0] busy_len;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Counts the self-timed cycle so its length can be judged at the end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_len <= 20'h0;
    end else begin
      busy_len <= busy ? busy_len + 20'h1 : 20'h0;
    end
  end

  data_hold_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("device data moved while clock high");
  start_master_a: assert property (
    $fell(sda) && scl && $past(scl) |-> !sda_s_oe)
    else $error("device took part in a start");
  stop_quiet_a: assert property (
    $rose(sda) && scl && $past(scl) |=> !sda_s_oe [*8])
    else $error("device drove data after a stop");
  busy_quiet_a: assert property (busy |-> !sda_s_oe)
    else $error("device drove data while busy");
  busy_len_a: assert property (
    $fell(busy) |-> busy_len >= WRITE_CYCLES - 1
    && busy_len <= WRITE_CYCLES + 1)
    else $error("write cycle length wrong");
  busy_stop_a: assert property ($rose(busy) |-> scl && sda)
    else $error("write cycle began outside a stop");
  busy_gate_a: assert property ($rose(busy) |-> ctrl_value[CR_WEL])
    else $error("write cycle began with enable latch low");
  wel_stop_a: assert property ($rose(ctrl_value[CR_WEL]) |-> scl && sda)
    else $error("enable latch set outside a stop");
  hw_lock_a: assert property (
    wp_pin && $past(wp_pin, 4) && ctrl_value[CR_HWPE]
    |=> $stable({ctrl_value[7], ctrl_value[4:3], ctrl_value[0]}))
    else $error("protect bits changed under hardware lock");
endmodule
`default_nettype wire

// File: test_serial_eeprom_write_protect_slave.sv
// Self-checking bench joining bus master and EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_write_protect_slave;
  import eewp_pkg::*;
  localparam int WC = 200;
  logic ref_clk = 1'b0, reset_n = 1'b0, wp_pin = 1'b0, cmd_valid = 1'b0;
  logic saw_full = 1'b0, cmd_ready, ack_seen, idle, busy;
  logic saw_rx = 1'b0, rx_valid;
  logic [10:0] cmd_data = 11'h0;
  logic [7:0] rx_data, ctrl_value;
  int n_fail = 0, num_checks = 0, cyc = 0;
  // ------------------------------------------------------------
  // Rows: wp, wait-busy, control check, command, expected
  // ------------------------------------------------------------
  logic [23:0] rows [$] = {
    24'h100060, 24'h04a001, 24'h000001, 24'h001001, 24'h025500,
    24'h06a200,
    24'h04a001, 24'h00ff01, 24'h00ff01, 24'h020201, 24'h100062,
    24'h04a001, 24'h00ff01, 24'h00ff01, 24'h04a101, 24'h030062,
    24'h04a001, 24'h00ff01, 24'h00ff01, 24'h020601, 24'h100066,
    24'h04a001, 24'h00ff01, 24'h00ff01, 24'h028a01, 24'h06a000,
    24'h200000, 24'h10008a,
    24'h04a001, 24'h003001, 24'h000001, 24'h027700,
    24'h04a001, 24'h000001, 24'h003e01, 24'h001101, 24'h002201,
    24'h023301, 24'h200000, 24'h04a001, 24'h000001, 24'h003e01,
    24'h04a101, 24'h010011, 24'h030022,
    24'h04a001, 24'h000001, 24'h000001, 24'h04a101, 24'h030033,
    24'h84a001, 24'h80ff01, 24'h80ff01, 24'h820201, 24'h84a001,
    24'h80ff01, 24'h80ff01, 24'h820601, 24'h84a001, 24'h80ff01,
    24'h80ff01, 24'h820200, 24'h10008e, 24'h84a001, 24'h800001,
    24'h802001, 24'h829901, 24'ha00000,
    24'h04a001, 24'h00ff01, 24'h00ff01, 24'h020e01, 24'h200000,
    24'h10000e,
    24'h04a001, 24'h000001, 24'h025001, 24'h06a001,
    24'h04a001, 24'h00ff01, 24'h00ff01, 24'h000201, 24'h020600,
    24'h10000e};

  always #12.5 ref_clk = ~ref_clk;

  eewp_if bus_if();
  eewp_host u_eewp_host (.ref_clk(ref_clk), .reset_n(reset_n),
    .clk_en(1'b1), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_data(cmd_data), .rx_valid(rx_valid), .rx_data(rx_data),
    .ack_seen(ack_seen), .idle(idle), .bus(bus_if));
  eewp_device #(.WRITE_CYCLES(WC)) u_eewp_device (.ref_clk(ref_clk),
    .reset_n(reset_n), .clk_en(1'b1), .wp_pin(wp_pin), .bus(bus_if),
    .busy(busy), .ctrl_value(ctrl_value));
  eewp_sva #(.WRITE_CYCLES(WC)) u_eewp_sva (.ref_clk(ref_clk),
    .reset_n(reset_n), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_s_oe(bus_if.sda_s_oe), .wp_pin(wp_pin), .busy(busy),
    .ctrl_value(ctrl_value));

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Held valid is lowered by the caller, so back-to-back pushes stay clean
  task push(input logic [10:0] c);
    cmd_data = c;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin
      @(posedge ref_clk);
      #2;
    end
    @(posedge ref_clk);
    #2;
  endtask

  // Stop detection comes two cycles before the host goes idle; the lead-in only adds margin
  task wt(input logic b);
    if (b) begin
      repeat (8) @(posedge ref_clk);
      #2;
    end
    for (int k = 0; k < 4000 && (b ? busy : !idle); k++) begin
      @(posedge ref_clk);
      #2;
    end
  endtask

  task xfer(input logic [23:0] r);
    wp_pin = r[23];
    if (r[20]) begin
      chk(ctrl_value, r[7:0]);
    end else if (r[21]) begin
      wt(1'b1);
    end else begin
      push(r[18:8]);
      cmd_valid = 1'b0;
      wt(1'b0);
      chk(r[16] ? rx_data : {7'h0, ack_seen}, r[7:0]);
    end
  endtask

  task finish_test;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cmd_valid && !cmd_ready) saw_full <= 1'b1;
    if (rx_valid === 1'b1) saw_rx <= 1'b1;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    #2;
    reset_n = 1'b1;
    foreach (rows[i]) xfer(rows[i]);
    push(11'h4a0);
    push(11'h000);
    push(11'h080);
    for (int i = 0; i < 66; i++) push({1'b0, i == 65, 1'b0, i[7:0]});
    cmd_valid = 1'b0;
    wt(1'b0);
    chk({7'h0, saw_full}, 8'h01);
    chk({7'h0, saw_rx}, 8'h01);
    chk({7'h0, ack_seen}, 8'h01);
    xfer(24'h200000);
    xfer(24'h04a001);
    xfer(24'h000001);
    xfer(24'h008001);
    xfer(24'h04a101);
    xfer(24'h010040);
    xfer(24'h030041);
    reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
    xfer(24'h100060);
    chk({7'h0, busy}, 8'h00);
    reset_n = 1'b1;
    xfer(24'h06a001);
    finish_test();
  end
endmodule
`default_nettype wire
